// File: pkg/ao_scale_pkg.sv
// Constants for the analog output calibration and scaling register bank
package ao_scale_pkg;
   // Register index = channel * CH_STRIDE + subindex; byte address = index * 4
   localparam logic [7:0] CH_STRIDE = 8'h20;
   localparam logic [4:0] SUB_SCALE_EN = 5'h01;
   localparam logic [4:0] SUB_UCAL_EN = 5'h07;
   localparam logic [4:0] SUB_VCAL_EN = 5'h08;
   localparam logic [4:0] SUB_SCALE_OFS = 5'h11;
   localparam logic [4:0] SUB_SCALE_GAIN = 5'h12;
   localparam logic [4:0] SUB_UCAL_OFS = 5'h15;
   localparam logic [4:0] SUB_UCAL_GAIN = 5'h16;
   localparam logic [4:0] SUB_VEND_GAIN = 5'h1D;
   localparam logic [4:0] SUB_VEND_OFS = 5'h1E;
   localparam logic [4:0] SUB_OUT_VAL = 5'h1F;
   localparam logic [7:0] IDX_RESTORE = 8'h81;
   // Restore keys
   localparam logic [31:0] KEY_RESTORE = 32'h64616F6C;
   localparam logic [31:0] KEY_RESTORE_ALT = 32'h6C6F6164;
   // Delivery values
   localparam logic DEF_SCALE_EN = 1'b0;
   localparam logic DEF_UCAL_EN = 1'b0;
   localparam logic DEF_VCAL_EN = 1'b1;
   localparam logic [15:0] DEF_SCALE_OFS = 16'h0000;
   localparam logic [31:0] DEF_SCALE_GAIN = 32'h0000FFFF;
   localparam logic [15:0] DEF_UCAL_OFS = 16'h0000;
   localparam logic [15:0] DEF_UCAL_GAIN = 16'h4000;
   // Fixed point: scaling gain unity is 2^16, calibration gains unity is 2^14
   localparam int SCALE_FRAC = 16;
   localparam int CAL_FRAC = 14;
   localparam logic [31:0] SCALE_UNITY = 32'h00010000;
   localparam logic [15:0] CAL_UNITY = 16'h4000;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK = 2'b01
   } bus_st_e;
endpackage : ao_scale_pkg

// File: hdl/ao_lin_stage.sv
// One linear correction stage y = g * x >>> FRAC + o with saturation and bypass
`timescale 1ns/10ps
module ao_lin_stage #(
   parameter int GW = 16,
   parameter int FRAC = 14
) (
   input wire logic en,
   input wire logic signed [15:0] x,
   input wire logic signed [GW-1:0] g,
   input wire logic signed [15:0] o,
   output logic signed [15:0] y
);
   localparam int PW = 16 + GW;

   if (GW < 2 || GW > 32 || FRAC >= PW) begin : g_bad_param
      $error("ao_lin_stage: unsupported gain width or fraction");
   end

   logic signed [PW-1:0] prod;
   logic signed [PW:0] sum;

   always_comb begin
      prod = x * g;
      sum = (PW+1)'(prod >>> FRAC) + (PW+1)'(o);
      if (!en) begin
         y = x;
      end else if (sum > (PW+1)'(32767)) begin
         y = 16'sh7FFF;
      end else if (sum < -(PW+1)'(32768)) begin
         y = -16'sh8000;
      end else begin
         y = sum[15:0];
      end
   end
endmodule : ao_lin_stage

// File: hdl/ao_scale_top.sv
// Analog output parameter bank with vendor, user calibration and user scaling path
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
// Contract
// - With scaling on, a channel outputs scaling gain times its value plus scaling offset.
// - Scaling is off after delivery and is switched on per channel at subindex 01.
// - Each channel holds a writable scaling offset at subindex 11h and gain at 12h.
// - Each channel holds a writable calibration offset at subindex 15h and gain at 16h.
// - Writing key 64616F6Ch to the restore subindex requests delivery settings.
// - An accepted restore key returns every backup parameter to its delivery value.
// - The alternative key 6C6F6164h is accepted as a restore request as well.
// - Any other value written to the restore subindex changes nothing.
// - User calibration is a gain and offset correction, off by default, enabled at 07.
// - A fixed vendor correction with read-only coefficients is applied to each output.
module ao_scale_top
   import ao_scale_pkg::*;
#(
   parameter int NCH = 4,
   parameter logic [15:0] VEND_GAIN = 16'h4000,
   parameter logic [15:0] VEND_OFS = 16'h0000
) (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic CE,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [9:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   input wire logic [NCH-1:0][15:0] AO_IN,
   output logic [NCH-1:0][15:0] AO_OUT
);
   if (NCH < 2 || NCH > 4) begin : g_bad_nch
      $error("ao_scale_top: NCH must be 2 to 4");
   end

   typedef struct packed {
      bus_st_e bst;
      logic [31:0] rdata;
      logic [NCH-1:0] sc_en;
      logic [NCH-1:0] uc_en;
      logic [NCH-1:0] vc_en;
      logic [NCH-1:0][15:0] sc_ofs;
      logic [NCH-1:0][31:0] sc_gain;
      logic [NCH-1:0][15:0] uc_ofs;
      logic [NCH-1:0][15:0] uc_gain;
      logic [NCH-1:0][15:0] v_stage;
      logic [NCH-1:0][15:0] u_stage;
      logic [NCH-1:0][15:0] out;
   } st_s;

   st_s st_r;
   st_s st_nxt;
   logic [NCH-1:0][15:0] vend_y;
   logic [NCH-1:0][15:0] ucal_y;
   logic [NCH-1:0][15:0] scale_y;

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            m[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return m;
   endfunction : merge

   // Return every backup parameter to its delivery value
   function automatic st_s defaults(input st_s s);
      st_s d;
      d = s;
      d.sc_en = {NCH{DEF_SCALE_EN}};
      d.uc_en = {NCH{DEF_UCAL_EN}};
      d.vc_en = {NCH{DEF_VCAL_EN}};
      d.sc_ofs = {NCH{DEF_SCALE_OFS}};
      d.sc_gain = {NCH{DEF_SCALE_GAIN}};
      d.uc_ofs = {NCH{DEF_UCAL_OFS}};
      d.uc_gain = {NCH{DEF_UCAL_GAIN}};
      return d;
   endfunction : defaults

   // Read value of a channel register; zero for unmapped subindices
   function automatic logic [31:0] rd_chan(input st_s s, input int c, input logic [4:0] sub);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (sub == SUB_SCALE_EN) begin
         v[0] = s.sc_en[c];
      end else if (sub == SUB_UCAL_EN) begin
         v[0] = s.uc_en[c];
      end else if (sub == SUB_VCAL_EN) begin
         v[0] = s.vc_en[c];
      end else if (sub == SUB_SCALE_OFS) begin
         v[15:0] = s.sc_ofs[c];
      end else if (sub == SUB_SCALE_GAIN) begin
         v = s.sc_gain[c];
      end else if (sub == SUB_UCAL_OFS) begin
         v[15:0] = s.uc_ofs[c];
      end else if (sub == SUB_UCAL_GAIN) begin
         v[15:0] = s.uc_gain[c];
      end else if (sub == SUB_VEND_GAIN) begin
         v[15:0] = VEND_GAIN;
      end else if (sub == SUB_VEND_OFS) begin
         v[15:0] = VEND_OFS;
      end else if (sub == SUB_OUT_VAL) begin
         v[15:0] = s.out[c];
      end
      return v;
   endfunction : rd_chan

   // Three correction stages per channel, each bypassed by its enable
   for (genvar c = 0; c < NCH; c++) begin : g_chan
      ao_lin_stage #(.GW(16), .FRAC(CAL_FRAC)) u_vend (
         .en(st_r.vc_en[c]),
         .x(AO_IN[c]),
         .g(VEND_GAIN),
         .o(VEND_OFS),
         .y(vend_y[c])
      );
      ao_lin_stage #(.GW(16), .FRAC(CAL_FRAC)) u_ucal (
         .en(st_r.uc_en[c]),
         .x(st_r.v_stage[c]),
         .g(st_r.uc_gain[c]),
         .o(st_r.uc_ofs[c]),
         .y(ucal_y[c])
      );
      ao_lin_stage #(.GW(32), .FRAC(SCALE_FRAC)) u_scale (
         .en(st_r.sc_en[c]),
         .x(st_r.u_stage[c]),
         .g(st_r.sc_gain[c]),
         .o(st_r.sc_ofs[c]),
         .y(scale_y[c])
      );
   end

   logic accept;
   logic [7:0] idx;
   logic in_chan;
   int chi;
   logic [4:0] sub;
   logic [31:0] wm;

   always_comb begin
      st_nxt = st_r;
      accept = CYC_I && STB_I && (st_r.bst == BUS_IDLE);
      idx = ADR_I[9:2];
      chi = int'(idx[6:5]);
      sub = idx[4:0];
      in_chan = !idx[7] && (chi < NCH);
      wm = 32'h0000_0000;
      st_nxt.v_stage = vend_y;
      st_nxt.u_stage = ucal_y;
      st_nxt.out = scale_y;
      case (st_r.bst)
         BUS_IDLE: begin
            if (accept) begin
               st_nxt.bst = BUS_ACK;
            end
         end
         BUS_ACK: begin
            st_nxt.bst = BUS_IDLE;
         end
         default: begin
            st_nxt.bst = BUS_IDLE;
         end
      endcase
      if (accept && !WE_I) begin
         st_nxt.rdata = in_chan ? rd_chan(st_r, chi, sub) : 32'h0000_0000;
      end
      if (accept && WE_I && in_chan) begin
         // Each write touches only the addressed channel
         wm = merge(rd_chan(st_r, chi, sub), DAT_I, SEL_I);
         if (sub == SUB_SCALE_EN) begin
            st_nxt.sc_en[chi] = wm[0];
         end else if (sub == SUB_UCAL_EN) begin
            st_nxt.uc_en[chi] = wm[0];
         end else if (sub == SUB_VCAL_EN) begin
            st_nxt.vc_en[chi] = wm[0];
         end else if (sub == SUB_SCALE_OFS) begin
            st_nxt.sc_ofs[chi] = wm[15:0];
         end else if (sub == SUB_SCALE_GAIN) begin
            st_nxt.sc_gain[chi] = wm;
         end else if (sub == SUB_UCAL_OFS) begin
            st_nxt.uc_ofs[chi] = wm[15:0];
         end else if (sub == SUB_UCAL_GAIN) begin
            st_nxt.uc_gain[chi] = wm[15:0];
         end
      end else if (accept && WE_I && idx == IDX_RESTORE) begin
         // Keys must be written as a full word; any other value is dropped
         if (SEL_I == 4'hF
             && (DAT_I == KEY_RESTORE || DAT_I == KEY_RESTORE_ALT)) begin
            st_nxt = defaults(st_nxt);
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         st_r <= defaults('0);
      end else if (CE) begin
         st_r <= st_nxt;
      end
   end

   // BUS_ACK is the only bus state with bit 0 set, so the flop drives the pin
   assign ACK_O = st_r.bst[0];
   assign DAT_O = st_r.rdata;
   assign AO_OUT = st_r.out;

   logic wr_restore;
   assign wr_restore = CE && CYC_I && STB_I && WE_I && !ACK_O && ADR_I[9:2] == IDX_RESTORE;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   chk_ack_follow: assert property (CE && CYC_I && STB_I && !ACK_O |=> ACK_O)
      else $error("request not acknowledged in next cycle");
   chk_ack_single: assert property (CE && ACK_O |=> !ACK_O)
      else $error("acknowledge held longer than one cycle");
   chk_reset_defaults: assert property (
      $fell(SRST) |-> st_r.sc_en == '0 && st_r.uc_en == '0)
      else $error("enables not off after reset");
   chk_restore_key: assert property (
      wr_restore && SEL_I == 4'hF && DAT_I == KEY_RESTORE
      |=> st_r.sc_gain[0] == DEF_SCALE_GAIN && st_r.uc_gain[NCH-1] == DEF_UCAL_GAIN
          && st_r.sc_en == '0)
      else $error("restore key did not return delivery values");
   chk_restore_alt: assert property (
      wr_restore && SEL_I == 4'hF && DAT_I == KEY_RESTORE_ALT
      |=> st_r.sc_ofs[0] == DEF_SCALE_OFS && st_r.vc_en == '1 && st_r.uc_en == '0)
      else $error("alternative key did not restore");
   chk_bad_key: assert property (
      wr_restore && DAT_I != KEY_RESTORE && DAT_I != KEY_RESTORE_ALT
      |=> $stable(st_r.sc_gain) && $stable(st_r.sc_en) && $stable(st_r.uc_gain))
      else $error("wrong key changed parameters");
   chk_ofs_write: assert property (
      CE && CYC_I && STB_I && WE_I && !ACK_O && SEL_I == 4'hF
      && ADR_I[9:2] == {3'b000, SUB_UCAL_OFS} |=> st_r.uc_ofs[0] == $past(DAT_I[15:0]))
      else $error("calibration offset write lost");
   chk_chan_indep: assert property (
      CE && CYC_I && STB_I && WE_I && !ACK_O && ADR_I[9:7] == 3'b000
      |=> $stable(st_r.sc_gain[1]) && $stable(st_r.sc_ofs[1]) && $stable(st_r.uc_en[1]))
      else $error("write to channel 0 disturbed channel 1");
   chk_scale_unity: assert property (
      CE && st_r.sc_en[0] && st_r.sc_gain[0] == SCALE_UNITY
      && st_r.sc_ofs[0] == 16'h0000 |=> AO_OUT[0] == $past(st_r.u_stage[0]))
      else $error("unity scaling altered value");
   chk_scale_bypass: assert property (
      CE && !st_r.sc_en[0] |=> AO_OUT[0] == $past(st_r.u_stage[0]))
      else $error("disabled scaling not bypassed");
   chk_ucal_unity: assert property (
      CE && st_r.uc_en[0] && st_r.uc_gain[0] == CAL_UNITY && st_r.uc_ofs[0] == 16'h0000
      |=> st_r.u_stage[0] == $past(st_r.v_stage[0]))
      else $error("unity calibration altered value");
   chk_path_latency: assert property (
      CE && !st_r.vc_en[0] && !st_r.uc_en[0] && !st_r.sc_en[0]
      ##1 (CE && !st_r.uc_en[0] && !st_r.sc_en[0]) ##1 (CE && !st_r.sc_en[0])
      |=> AO_OUT[0] == $past(AO_IN[0], 3))
      else $error("bypassed path latency is not three cycles");

   cov_restore: cover property (wr_restore && DAT_I == KEY_RESTORE);
   cov_restore_alt: cover property (wr_restore && DAT_I == KEY_RESTORE_ALT);
   cov_scale_on: cover property (st_r.sc_en[0] && st_r.uc_en[0] && AO_OUT[0] != 16'h0000);
   cov_read: cover property (ACK_O && !WE_I);
endmodule : ao_scale_top

// File: testbench/ao_bus_master.sv
// Wishbone classic master that stands in for the fieldbus parameter master
`timescale 1ns/10ps
module ao_bus_master (
   input wire logic clk,
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [9:0] adr,
   output logic [3:0] sel,
   output logic [31:0] dat_w,
   input wire logic [31:0] dat_r,
   input wire logic ack
);
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 10'h000;
      sel = 4'h0;
      dat_w = 32'h00000000;
   end
   // One single cycle, held until ack is sampled high at a rising edge
   task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= wr;
      adr <= a;
      sel <= 4'hF;
      dat_w <= d;
      @(posedge clk);
      while (ack !== 1'b1) begin
         @(posedge clk);
      end
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      dat_w <= ~d;
   endtask : xfer
endmodule : ao_bus_master

// File: testbench/ao_user_scaling_and_restore_tb.sv
// Self-checking bench for the analog output scaling and restore bank
`timescale 1ns/10ps
module ao_user_scaling_and_restore_tb;
   import ao_scale_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic cyc, stb, we, ack;
   logic [9:0] adr;
   logic [3:0] sel;
   logic [31:0] dat_w, dat_r, q;
   logic [3:0][15:0] ao_in = '0;
   logic [3:0][15:0] ao_out;
   int mismatches = 0;
   int check_count = 0;
   logic signed [15:0] so[4], co[4], cg[4];
   logic signed [31:0] sg[4];
   logic sen[4], cen[4], ven[4];
   logic [15:0] held[4];

   ao_scale_top dut_u (.CLK(clk), .SRST(srst), .CE(ce), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
      .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
      .AO_IN(ao_in), .AO_OUT(ao_out));
   ao_bus_master bm_u (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
      .dat_w(dat_w), .dat_r(dat_r), .ack(ack));

   initial begin
      forever #12.5 clk = ~clk;
   end

   function automatic logic [9:0] ra(int c, logic [4:0] s);
      return 10'((c * CH_STRIDE + s) * 4);
   endfunction : ra

   function automatic logic [15:0] lin(logic signed [15:0] x, logic signed [31:0] g,
                                       logic signed [15:0] o, int fr);
      longint p;
      p = ((longint'(x) * longint'(g)) >>> fr) + longint'(o);
      if (p > 32767) p = 32767;
      if (p < -32768) p = -32768;
      return 16'(p);
   endfunction : lin

   function automatic logic [15:0] exp_out(int c, logic [15:0] x);
      logic [15:0] y;
      y = x;
      if (ven[c]) y = lin(y, 32'sh4000, 16'sh0000, CAL_FRAC);
      if (cen[c]) y = lin(y, cg[c], co[c], CAL_FRAC);
      if (sen[c]) y = lin(y, sg[c], so[c], SCALE_FRAC);
      return y;
   endfunction : exp_out

   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic chk_out(int c, logic [15:0] e);
      check_count++;
      if (ao_out[c] !== e) begin
         mismatches++;
         $display("unexpected AO_OUT[%0d] expected %h seen %h", c, e, ao_out[c]);
      end
   endtask : chk_out

   task automatic wr(logic [9:0] a, logic [31:0] d);
      bm_u.xfer(1'b1, a, d, q);
   endtask : wr

   task automatic rd(string n, logic [9:0] a, logic [31:0] e);
      bm_u.xfer(1'b0, a, 32'h00000000, q);
      chk(n, e, q);
   endtask : rd

   task automatic defaults();
      for (int c = 0; c < 4; c++) begin
         rd("scale_en", ra(c, SUB_SCALE_EN), 32'(DEF_SCALE_EN));
         rd("ucal_en", ra(c, SUB_UCAL_EN), 32'(DEF_UCAL_EN));
         rd("vcal_en", ra(c, SUB_VCAL_EN), 32'(DEF_VCAL_EN));
         rd("scale_ofs", ra(c, SUB_SCALE_OFS), 32'(DEF_SCALE_OFS));
         rd("scale_gain", ra(c, SUB_SCALE_GAIN), DEF_SCALE_GAIN);
         rd("ucal_ofs", ra(c, SUB_UCAL_OFS), 32'(DEF_UCAL_OFS));
         rd("ucal_gain", ra(c, SUB_UCAL_GAIN), 32'(DEF_UCAL_GAIN));
         sen[c] = 1'b0;
         cen[c] = 1'b0;
         ven[c] = DEF_VCAL_EN;
      end
   endtask : defaults

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      results();
   end

   initial begin
      void'($urandom(32'hFC88));
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      defaults();
      for (int r = 0; r < 4; r++) begin
         for (int c = 0; c < 4; c++) begin
            // First round enables scaling on channel 0 and calibration on channel 1 only, to expose coupling
            sen[c] = (r == 0) ? (c == 0) : 1'($urandom);
            cen[c] = (r == 0) ? (c == 1) : 1'($urandom);
            so[c] = 16'($urandom);
            co[c] = 16'($urandom);
            cg[c] = 16'($urandom);
            sg[c] = 32'($urandom_range(0, 32'h3FFFF)) - 32'h1FFFF;
            if (r == 3 && c == 0) begin
               // Both user stages on but transparent
               sen[c] = 1'b1;
               cen[c] = 1'b1;
               so[c] = 16'h0000;
               co[c] = 16'h0000;
               cg[c] = CAL_UNITY;
               sg[c] = SCALE_UNITY;
            end
            wr(ra(c, SUB_SCALE_EN), 32'(sen[c]));
            wr(ra(c, SUB_UCAL_EN), 32'(cen[c]));
            wr(ra(c, SUB_SCALE_OFS), {16'h0000, so[c]});
            wr(ra(c, SUB_SCALE_GAIN), sg[c]);
            wr(ra(c, SUB_UCAL_OFS), {16'h0000, co[c]});
            wr(ra(c, SUB_UCAL_GAIN), {16'h0000, cg[c]});
            wr(ra(c, SUB_VEND_GAIN), 32'h00001234);
         end
         for (int c = 0; c < 4; c++) begin
            rd("scale_gain", ra(c, SUB_SCALE_GAIN), sg[c]);
            rd("ucal_ofs", ra(c, SUB_UCAL_OFS), {16'h0000, co[c]});
            rd("vend_gain", ra(c, SUB_VEND_GAIN), 32'h00004000);
         end
         // Clock enable low freezes the pipeline on the previous input
         for (int c = 0; c < 4; c++) held[c] = exp_out(c, ao_in[c]);
         ao_in <= {$urandom, $urandom};
         ce <= 1'b0;
         repeat (5) @(posedge clk);
         for (int c = 0; c < 4; c++) chk_out(c, held[c]);
         ce <= 1'b1;
         repeat (5) @(posedge clk);
         for (int c = 0; c < 4; c++) chk_out(c, exp_out(c, ao_in[c]));
         if (r == 1) begin
            wr(10'h204, KEY_RESTORE ^ 32'h00000100);
            for (int c = 0; c < 4; c++) rd("kept_gain", ra(c, SUB_SCALE_GAIN), sg[c]);
         end
         if (r == 2) begin
            wr(10'h204, KEY_RESTORE);
            defaults();
         end
      end
      // Every stage of channel 0 bypassed: output is the input three cycles late
      wr(ra(0, SUB_VCAL_EN), 32'h00000000);
      wr(ra(0, SUB_UCAL_EN), 32'h00000000);
      wr(ra(0, SUB_SCALE_EN), 32'h00000000);
      ven[0] = 1'b0;
      cen[0] = 1'b0;
      sen[0] = 1'b0;
      rd("vcal_en", ra(0, SUB_VCAL_EN), 32'h00000000);
      ao_in <= {$urandom, $urandom};
      repeat (5) @(posedge clk);
      for (int c = 0; c < 4; c++) chk_out(c, exp_out(c, ao_in[c]));
      wr(10'h204, KEY_RESTORE_ALT);
      defaults();
      repeat (5) @(posedge clk);
      for (int c = 0; c < 4; c++) chk_out(c, exp_out(c, ao_in[c]));
      rd("unmapped", 10'h200, 32'h00000000);
      rd("restore", 10'h204, 32'h00000000);
      rd("vend_ofs", ra(1, SUB_VEND_OFS), 32'h00000000);
      rd("out_val", ra(0, SUB_OUT_VAL), {16'h0000, exp_out(0, ao_in[0])});
      results();
   end
endmodule : ao_user_scaling_and_restore_tb
